// ==== verilog/bmw_pkg.sv ====
/*
 * Constants for the bridge memory window register bank: register
 * indexes and byte addresses, field positions, reset values, bus
 * response codes and the register select type.
 * Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
 */
package bmw_pkg;

	// ********************************************
	// Bus geometry
	// ********************************************
	localparam int ADDR_W = 12;            // Byte address width
	localparam int IDX_W = 8;              // Register index width

	// ********************************************
	// Register indexes; byte address is four times the index
	// ********************************************
	localparam logic [IDX_W-1:0] NP_BASE_IDX = 8'h20;
	localparam logic [IDX_W-1:0] NP_LIMIT_IDX = 8'h22;
	localparam logic [IDX_W-1:0] PF_BASE_IDX = 8'h24;
	localparam logic [IDX_W-1:0] PF_LIMIT_IDX = 8'h26;
	localparam logic [IDX_W-1:0] PF_BASE_HI_IDX = 8'h28;
	localparam logic [IDX_W-1:0] PF_LIMIT_HI_IDX = 8'h2C;
	localparam logic [IDX_W-1:0] CTRL_IDX = 8'hFC;   // Lock control
	localparam logic [ADDR_W-1:0] NP_BASE_ADDR = {2'h0, NP_BASE_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] NP_LIMIT_ADDR = {2'h0, NP_LIMIT_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] PF_BASE_ADDR = {2'h0, PF_BASE_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] PF_LIMIT_ADDR = {2'h0, PF_LIMIT_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] PF_BASE_HI_ADDR =
		{2'h0, PF_BASE_HI_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] PF_LIMIT_HI_ADDR =
		{2'h0, PF_LIMIT_HI_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};

	// ********************************************
	// Field positions
	// ********************************************
	localparam int WIN_LSB = 4;            // Window field low bit
	localparam int WIN_MSB = 15;           // Window field high bit
	localparam int CAP_BIT = 0;            // 64-bit capability bit
	localparam int UNLOCK_BIT = 0;         // Capability write unlock
	localparam int WIN_W = WIN_MSB - WIN_LSB + 1;
	localparam int LOW_W = 20;             // Address bits below window

	// ********************************************
	// Reset values and fixed address fill
	// ********************************************
	localparam logic [WIN_W-1:0] WIN_BASE_RST = 12'hFFF;
	localparam logic [WIN_W-1:0] WIN_LIMIT_RST = 12'h000;
	localparam logic CAP_RST = 1'h1;
	localparam logic UNLOCK_RST = 1'h0;
	localparam logic [31:0] HI_BASE_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] HI_LIMIT_RST = 32'h0000_0000;
	localparam logic [LOW_W-1:0] LOW_ONES = 20'hF_FFFF;
	localparam logic [LOW_W-1:0] LOW_ZERO = 20'h0_0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ********************************************
	// Bus responses and register select
	// ********************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_NP_BASE,
		SEL_NP_LIMIT,
		SEL_PF_BASE,
		SEL_PF_LIMIT,
		SEL_PF_BASE_HI,
		SEL_PF_LIMIT_HI,
		SEL_CTRL
	} bmw_sel_t;

endpackage

// ==== verilog/bmw_window_regs.sv ====
/*
 * Bridge memory window register bank with AXI4-Lite slave and the
 * window match that steers forwarding of memory transactions.
 * Assumes one synchronous clock, synchronous active-low reset, and a
 * lookup requester that presents one address per valid cycle.
 */
// Added by the designer: the AXI4-Lite slave port.
// Function
// - Non-prefetchable base bits 15:4, reset all ones
// - Non-prefetchable limit bits 15:4, low bits ones
// - Non-prefetchable window decides forwarding
// - Capability bit selects 32/64, writable when unlocked
// - Limit bit 0 mirrors capability, read-only
// - Prefetchable base bits 15:4, reset all ones
// - Prefetchable limit bits 15:4, low bits ones
// - Prefetchable window with upper bits forwards
// - Capability clear: upper registers read zero, locked
`timescale 1ns/1ns
module bmw_window_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [bmw_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [bmw_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	input wire logic mem_req_pref,
	output logic fwd_valid,
	output logic fwd_hit
);
	import bmw_pkg::*;

	// ********************************************
	// Functions
	// ********************************************
	// Byte address to register select; bits above the map are unmapped
	function automatic bmw_sel_t decode(logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] idx;
		idx = a[IDX_W+1:2];
		if (a[ADDR_W-1:IDX_W+2] != '0) return SEL_NONE;
		else if (idx == NP_BASE_IDX) return SEL_NP_BASE;
		else if (idx == NP_LIMIT_IDX) return SEL_NP_LIMIT;
		else if (idx == PF_BASE_IDX) return SEL_PF_BASE;
		else if (idx == PF_LIMIT_IDX) return SEL_PF_LIMIT;
		else if (idx == PF_BASE_HI_IDX) return SEL_PF_BASE_HI;
		else if (idx == PF_LIMIT_HI_IDX) return SEL_PF_LIMIT_HI;
		else if (idx == CTRL_IDX) return SEL_CTRL;
		else return SEL_NONE;
	endfunction

	// Byte-lane merge of write data into the old word
	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] d, logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction

	// Inclusive window test; a base above the limit matches nothing
	function automatic logic in_window(logic [63:0] a,
		logic [63:0] b, logic [63:0] l);
		return (a >= b) && (a <= l);
	endfunction

	// ********************************************
	// State
	// ********************************************
	logic [WIN_W-1:0] np_base_r;      // Non-prefetchable base field
	logic [WIN_W-1:0] np_limit_r;     // Non-prefetchable limit field
	logic [WIN_W-1:0] pf_base_r;      // Prefetchable base field
	logic [WIN_W-1:0] pf_limit_r;     // Prefetchable limit field
	logic [31:0] pf_base_hi_r, pf_limit_hi_r; // Upper prefetchable bounds
	logic cap_r; // 64-bit capability
	logic unlock_r; // Capability write unlock
	logic aw_got_r, w_got_r; // Write address and data held
	logic [ADDR_W-1:0] aw_addr_r; // Held write address
	logic [31:0] w_data_r; // Held write data
	logic [3:0] w_strb_r; // Held write strobes
	logic awready_r, wready_r, bvalid_r; // Write channel outputs
	logic arready_r, rvalid_r; // Read channel outputs
	logic [1:0] bresp_r, rresp_r; // Response codes
	logic [31:0] rdata_r; // Read data held for the master
	logic fwd_valid_r, fwd_hit_r; // Forwarding decision outputs

	logic do_write; // Both halves present, no answer
	bmw_sel_t wsel, rsel; // Write and read targets
	logic [31:0] wword; // Merged write word base
	logic [31:0] rword; // Read mux result
	logic [31:0] base_hi_eff, limit_hi_eff; // Upper halves as used
	logic [63:0] np_lo, np_hi, pf_lo, pf_hi; // Assembled window bounds
	logic ar_hs; // Read address handshake

	assign do_write = aw_got_r && w_got_r && !bvalid_r;
	assign wsel = decode(aw_addr_r);
	assign rsel = decode(s_axi_araddr);
	assign ar_hs = s_axi_arvalid && arready_r;

	// Upper halves vanish in 32-bit mode
	assign base_hi_eff = cap_r ? pf_base_hi_r : WORD_ZERO;
	assign limit_hi_eff = cap_r ? pf_limit_hi_r : WORD_ZERO;

	// Window bounds: base low bits zero, limit low bits ones
	assign np_lo = {WORD_ZERO, np_base_r, LOW_ZERO};
	assign np_hi = {WORD_ZERO, np_limit_r, LOW_ONES};
	assign pf_lo = {base_hi_eff, pf_base_r, LOW_ZERO};
	assign pf_hi = {limit_hi_eff, pf_limit_r, LOW_ONES};

	// ********************************************
	// Write channel handshakes
	// ********************************************
	// Address and data are taken in either order, one write at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awready_r <= 1'b0;
			aw_got_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_got_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (do_write) begin
			aw_got_r <= 1'b0;
		end else if (!aw_got_r && !bvalid_r) begin
			// Reopen only once the previous answer is gone
			awready_r <= 1'b1;
		end
	end

	// Data half mirrors the address half
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wready_r <= 1'b0;
			w_got_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_got_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (do_write) begin
			w_got_r <= 1'b0;
		end else if (!w_got_r && !bvalid_r) begin
			wready_r <= 1'b1;
		end
	end

	// Write answer one cycle after both halves are held
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ********************************************
	// Register writes
	// ********************************************
	// Merge base is the register as it reads back
	always_comb begin
		case (wsel)
			SEL_NP_BASE: wword = {16'h0000, np_base_r, 4'h0};
			SEL_NP_LIMIT: wword = {16'h0000, np_limit_r, 4'h0};
			SEL_PF_BASE: wword = {16'h0000, pf_base_r, 3'h0, cap_r};
			SEL_PF_LIMIT: wword = {16'h0000, pf_limit_r, 3'h0, cap_r};
			SEL_PF_BASE_HI: wword = pf_base_hi_r;
			SEL_PF_LIMIT_HI: wword = pf_limit_hi_r;
			SEL_CTRL: wword = {31'h0000_0000, unlock_r};
			default: wword = WORD_ZERO;
		endcase
		wword = merge(wword, w_data_r, w_strb_r);
	end

	// Window fields; reserved low bits are never stored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			np_base_r <= WIN_BASE_RST;
			np_limit_r <= WIN_LIMIT_RST;
			pf_base_r <= WIN_BASE_RST;
			pf_limit_r <= WIN_LIMIT_RST;
		end else if (do_write) begin
			if (wsel == SEL_NP_BASE) begin
				np_base_r <= wword[WIN_MSB:WIN_LSB];
			end else if (wsel == SEL_NP_LIMIT) begin
				np_limit_r <= wword[WIN_MSB:WIN_LSB];
			end else if (wsel == SEL_PF_BASE) begin
				pf_base_r <= wword[WIN_MSB:WIN_LSB];
			end else if (wsel == SEL_PF_LIMIT) begin
				pf_limit_r <= wword[WIN_MSB:WIN_LSB];
			end
		end
	end

	// Capability only moves while unlocked; limit bit 0 is not a path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_r <= CAP_RST;
		end else if (do_write && wsel == SEL_PF_BASE && unlock_r) begin
			cap_r <= wword[CAP_BIT];
		end
	end

	// Unlock control for the capability bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			unlock_r <= UNLOCK_RST;
		end else if (do_write && wsel == SEL_CTRL) begin
			unlock_r <= wword[UNLOCK_BIT];
		end
	end

	// Upper halves ignore writes in 32-bit mode; stored value is kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pf_base_hi_r <= HI_BASE_RST;
			pf_limit_hi_r <= HI_LIMIT_RST;
		end else if (do_write && cap_r) begin
			if (wsel == SEL_PF_BASE_HI) begin
				pf_base_hi_r <= wword;
			end else if (wsel == SEL_PF_LIMIT_HI) begin
				pf_limit_hi_r <= wword;
			end
		end
	end

	// ********************************************
	// Read channel
	// ********************************************
	// Read mux; reserved bits read zero
	always_comb begin
		case (rsel)
			SEL_NP_BASE: rword = {16'h0000, np_base_r, 4'h0};
			SEL_NP_LIMIT: rword = {16'h0000, np_limit_r, 4'h0};
			SEL_PF_BASE: rword = {16'h0000, pf_base_r, 3'h0, cap_r};
			// Bit 0 mirrors the capability
			SEL_PF_LIMIT: rword = {16'h0000, pf_limit_r, 3'h0, cap_r};
			SEL_PF_BASE_HI: rword = base_hi_eff;
			SEL_PF_LIMIT_HI: rword = limit_hi_eff;
			SEL_CTRL: rword = {31'h0000_0000, unlock_r};
			default: rword = WORD_ZERO;
		endcase
	end

	// Data captured at the address handshake, held until taken
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= WORD_ZERO;
			rresp_r <= RESP_OKAY;
		end else if (ar_hs) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rword;
			rresp_r <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_r) begin
			if (s_axi_rready) rvalid_r <= 1'b0;
		end else begin
			arready_r <= 1'b1;
		end
	end

	// ********************************************
	// Forwarding decision
	// ********************************************
	// Non-prefetchable window is 32-bit only; upper address must be 0
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fwd_valid_r <= 1'b0;
			fwd_hit_r <= 1'b0;
		end else begin
			fwd_valid_r <= mem_req_valid;
			if (!mem_req_valid) begin
				fwd_hit_r <= 1'b0;
			end else if (mem_req_pref) begin
				fwd_hit_r <= in_window(mem_req_addr, pf_lo, pf_hi);
			end else begin
				fwd_hit_r <= in_window(mem_req_addr, np_lo, np_hi);
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign fwd_valid = fwd_valid_r;
	assign fwd_hit = fwd_hit_r;

	// ********************************************
	// Assertions
	// ********************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	np_reset_a: assert property (
		$past(rst_n) == 1'b0 |-> np_base_r == WIN_BASE_RST &&
		np_limit_r == WIN_LIMIT_RST)
		else $error("window fields not at reset value");
	pf_reset_a: assert property (
		$past(rst_n) == 1'b0 |-> pf_base_r == WIN_BASE_RST &&
		pf_limit_r == WIN_LIMIT_RST && cap_r == CAP_RST)
		else $error("prefetchable fields not at reset value");
	cap_lock_a: assert property (
		$changed(cap_r) |-> $past(unlock_r) && $past(do_write))
		else $error("capability moved while locked");
	cap_mirror_a: assert property (
		ar_hs && rsel == SEL_PF_LIMIT |=> rdata_r[CAP_BIT] == $past(cap_r))
		else $error("limit bit 0 does not mirror capability");
	upper_zero_a: assert property (
		ar_hs && !cap_r && (rsel == SEL_PF_BASE_HI ||
		rsel == SEL_PF_LIMIT_HI) |=> rdata_r == WORD_ZERO)
		else $error("upper register not zero in 32-bit mode");
	np_top_a: assert property (
		mem_req_valid && !mem_req_pref && np_base_r <= np_limit_r &&
		mem_req_addr == np_hi |=> fwd_hit_r)
		else $error("top of non-prefetchable window missed");
	np_empty_a: assert property (
		mem_req_valid && !mem_req_pref && np_base_r > np_limit_r
		|=> fwd_valid_r && !fwd_hit_r)
		else $error("inverted window matched");
	pf_high32_a: assert property (
		mem_req_valid && mem_req_pref && !cap_r &&
		mem_req_addr[63:32] != WORD_ZERO |=> !fwd_hit_r)
		else $error("32-bit window matched high address");
	pf_base_a: assert property (
		mem_req_valid && mem_req_pref && pf_lo <= pf_hi &&
		mem_req_addr == pf_lo |=> fwd_hit_r)
		else $error("bottom of prefetchable window missed");
	write_answer_a: assert property (
		do_write |=> s_axi_bvalid ##0 !aw_got_r && !w_got_r)
		else $error("write answer late");

	write_seen_c: cover property (do_write && wsel == SEL_PF_BASE);
	read_seen_c: cover property (ar_hs && rsel == SEL_PF_LIMIT_HI);
	pf_hit_c: cover property (mem_req_valid && mem_req_pref ##1 fwd_hit_r);
	np_hit_c: cover property (mem_req_valid && !mem_req_pref ##1 fwd_hit_r);

endmodule

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the bridge memory window register bank:
 * AXI4-Lite master tasks, lookup driver, queued expectations.
 * Assumes the design asserts its own rules inline, one clock.
 */
`timescale 1ns/1ns
module tb_top;
	import bmw_pkg::*;

	// ************************************
	// Signals and bookkeeping
	// ************************************
	logic clk;
	logic rst_n;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic mem_req_valid, mem_req_pref, fwd_valid, fwd_hit;
	logic [63:0] mem_req_addr, a;
	logic [31:0] seed, r;
	logic [1:0] exp_b[$];          // Expected write responses
	logic [33:0] exp_r[$];         // Expected {rresp, rdata}
	logic exp_f[$];                // Expected lookup decisions
	logic [1:0] eb;
	logic [33:0] er;
	logic ef;
	int error_cnt, n_tests;

	bmw_window_regs u_dut (.clk(clk), .rst_n(rst_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .mem_req_valid(mem_req_valid),
		.mem_req_addr(mem_req_addr), .mem_req_pref(mem_req_pref),
		.fwd_valid(fwd_valid), .fwd_hit(fwd_hit));

	// 50 ns period
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// ************************************
	// Helpers
	// ************************************
	// Fixed-seed xorshift so a failing run repeats exactly
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Register word as read: window field, bit 0, rest zero
	function logic [31:0] wv(input logic [11:0] f, input logic b0);
		return {16'h0000, f, 3'h0, b0};
	endfunction

	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task tend(input string nm);
		$display("test %s done", nm);
	endtask

	// Write: address and data offered together, each dropped when taken
	task wr(input logic [11:0] ad, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] rs);
		logic done;
		done = 1'h0;
		exp_b.push_back(rs);
		@(posedge clk);
		s_axi_awvalid <= 1'h1;
		s_axi_awaddr <= ad;
		s_axi_wvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_bready <= 1'h1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				done = 1'h1;
				s_axi_bready <= 1'h0;
			end
		end
	endtask

	// Read: rready held until the answer is sampled
	task rd(input logic [11:0] ad, input logic [31:0] d,
		input logic [1:0] rs);
		logic done;
		done = 1'h0;
		exp_r.push_back({rs, d});
		@(posedge clk);
		s_axi_arvalid <= 1'h1;
		s_axi_araddr <= ad;
		s_axi_rready <= 1'h1;
		while (!done) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				done = 1'h1;
				s_axi_rready <= 1'h0;
			end
		end
	endtask

	// One lookup per cycle, back to back until lk_end
	task lk(input logic [63:0] ad, input logic p, input logic e);
		mem_req_valid <= 1'h1;
		mem_req_addr <= ad;
		mem_req_pref <= p;
		exp_f.push_back(e);
		@(posedge clk);
	endtask

	task lk_end();
		mem_req_valid <= 1'h0;
	endtask

	// Verdict in one place; leftover notes mean lost answers
	task test_done();
		chk("pending", 64'(exp_b.size() + exp_r.size() + exp_f.size()),
			64'h0);
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ************************************
	// Output monitor: oldest note against each result
	// ************************************
	always @(posedge clk) begin
		if (rst_n && s_axi_bvalid && s_axi_bready) begin
			eb = exp_b.pop_front();
			chk("bresp", 64'(s_axi_bresp), 64'(eb));
		end
		if (rst_n && s_axi_rvalid && s_axi_rready) begin
			er = exp_r.pop_front();
			chk("rdata", 64'(s_axi_rdata), 64'(er[31:0]));
			chk("rresp", 64'(s_axi_rresp), 64'(er[33:32]));
		end
		if (rst_n && fwd_valid === 1'h1) begin
			ef = exp_f.pop_front();
			chk("fwd_hit", 64'(fwd_hit), 64'(ef));
		end else if (rst_n) begin
			chk("fwd_idle", 64'(fwd_hit), 64'h0);
		end
	end

	// Watchdog: whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		test_done();
	end

	// ************************************
	// Main sequence
	// ************************************
	initial begin
		seed = 32'h0000_0028;
		error_cnt = 0;
		n_tests = 0;
		rst_n = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, mem_req_valid, mem_req_pref} = 4'h0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		mem_req_addr = 64'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		// Reset values, unmapped read
		rd(NP_BASE_ADDR, wv(12'hFFF, 1'h0), 2'h0);
		rd(NP_LIMIT_ADDR, wv(12'h000, 1'h0), 2'h0);
		rd(PF_BASE_ADDR, wv(12'hFFF, 1'h1), 2'h0);
		rd(PF_LIMIT_ADDR, wv(12'h000, 1'h1), 2'h0);
		rd(PF_BASE_HI_ADDR, 32'hFFFF_FFFF, 2'h0);
		rd(PF_LIMIT_HI_ADDR, 32'h0000_0000, 2'h0);
		rd(12'h084, 32'h0000_0000, 2'h2);
		tend("reset");
		// Field placement and byte strobes
		r = xs();
		wr(NP_BASE_ADDR, r, 4'hF, 2'h0);
		rd(NP_BASE_ADDR, wv(r[15:4], 1'h0), 2'h0);
		wr(NP_BASE_ADDR, 32'hFFFF_FFFF, 4'h2, 2'h0);
		rd(NP_BASE_ADDR, wv({8'hFF, r[7:4]}, 1'h0), 2'h0);
		wr(NP_LIMIT_ADDR, 32'hFFFF_FFFF, 4'hF, 2'h0);
		rd(NP_LIMIT_ADDR, wv(12'hFFF, 1'h0), 2'h0);
		wr(12'h3F4, 32'hFFFF_FFFF, 4'hF, 2'h2);
		tend("fields");
		// Non-prefetchable window edges, then random addresses
		wr(NP_BASE_ADDR, 32'h0000_1000, 4'hF, 2'h0);
		wr(NP_LIMIT_ADDR, 32'h0000_1FF0, 4'hF, 2'h0);
		lk(64'h1000_0000, 1'h0, 1'h1);
		lk(64'h0FFF_FFFF, 1'h0, 1'h0);
		lk(64'h1FFF_FFFF, 1'h0, 1'h1);
		lk(64'h2000_0000, 1'h0, 1'h0);
		lk(64'h1_1000_0000, 1'h0, 1'h0);
		lk(64'h1000_0000, 1'h1, 1'h0);
		for (int i = 0; i < 24; i++) begin
			r = xs();
			a = {35'h0, r[28:0]};
			lk(a, 1'h0, a[31:20] >= 12'h100 && a[31:20] <= 12'h1FF);
		end
		lk_end();
		tend("nonpref window");
		// Capability locked; limit bit 0 read-only mirror
		wr(PF_BASE_ADDR, 32'h0000_0000, 4'hF, 2'h0);
		rd(PF_BASE_ADDR, wv(12'h000, 1'h1), 2'h0);
		wr(PF_LIMIT_ADDR, 32'h0000_FFF0, 4'hF, 2'h0);
		rd(PF_LIMIT_ADDR, wv(12'hFFF, 1'h1), 2'h0);
		// 64-bit prefetchable window
		wr(PF_BASE_HI_ADDR, 32'h0000_0001, 4'hF, 2'h0);
		wr(PF_LIMIT_HI_ADDR, 32'h0000_0002, 4'hF, 2'h0);
		rd(PF_LIMIT_HI_ADDR, 32'h0000_0002, 2'h0);
		lk({32'h1, 32'h0}, 1'h1, 1'h1);
		lk({32'h0, 32'hFFFF_FFFF}, 1'h1, 1'h0);
		lk({32'h2, 32'hFFFF_FFFF}, 1'h1, 1'h1);
		lk({32'h3, 32'h0}, 1'h1, 1'h0);
		lk({32'h1, 32'h0}, 1'h0, 1'h0);
		lk_end();
		tend("pref window");
		// Unlock, drop to 32-bit: upper words hidden and frozen
		wr(CTRL_ADDR, 32'h0000_0001, 4'hF, 2'h0);
		wr(PF_BASE_ADDR, 32'h0000_0000, 4'hF, 2'h0);
		rd(PF_BASE_ADDR, wv(12'h000, 1'h0), 2'h0);
		rd(PF_LIMIT_ADDR, wv(12'hFFF, 1'h0), 2'h0);
		rd(PF_BASE_HI_ADDR, 32'h0000_0000, 2'h0);
		wr(PF_BASE_HI_ADDR, 32'h0000_0005, 4'hF, 2'h0);
		rd(PF_LIMIT_HI_ADDR, 32'h0000_0000, 2'h0);
		lk(64'h1234_5678, 1'h1, 1'h1);
		lk({32'h1, 32'h0}, 1'h1, 1'h0);
		lk_end();
		wr(PF_BASE_ADDR, 32'h0000_0001, 4'hF, 2'h0);
		rd(PF_BASE_HI_ADDR, 32'h0000_0001, 2'h0);
		tend("capability");
		// Base above limit matches nothing
		wr(NP_BASE_ADDR, 32'h0000_3000, 4'hF, 2'h0);
		wr(NP_LIMIT_ADDR, 32'h0000_2000, 4'hF, 2'h0);
		lk(64'h2000_0000, 1'h0, 1'h0);
		lk(64'h2FFF_FFFF, 1'h0, 1'h0);
		lk(64'h3000_0000, 1'h0, 1'h0);
		lk_end();
		repeat (2) @(posedge clk);
		tend("empty window");
		test_done();
	end
endmodule
